// [include/disk_ctrl_pkg.sv]
package disk_ctrl_pkg;

  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 32;
  localparam int          REG_W           = 8;

  // Byte addresses are four times the register index
  localparam logic [7:0]  IDX_STATUS      = 8'h00;
  localparam logic [7:0]  IDX_ERROR       = 8'h01;
  localparam logic [7:0]  IDX_HDR_COUNT   = 8'h0f;
  localparam logic [7:0]  IDX_OP_CMD      = 8'h11;
  localparam logic [7:0]  IDX_FORMAT      = 8'h35;
  localparam logic [7:0]  IDX_DRIVE_CMD   = 8'h10;

  localparam int          OC_RESET        = 0;
  localparam int          OC_GIE          = 1;
  localparam int          OC_HDR_IE       = 2;
  localparam int          OC_RIN          = 3;
  localparam int          OC_ROUT         = 4;
  localparam int          OC_PRECOMP      = 5;
  localparam int          OC_CORR         = 6;
  localparam int          OC_LOCK         = 7;

  localparam int          DF_MFM          = 0;
  localparam int          DF_MARK_FIRST   = 1;
  localparam int          DF_HARD         = 2;
  localparam int          DF_HDR_SRC      = 3;
  localparam int          DF_HCODE_LO     = 4;
  localparam int          DF_DCODE_LO     = 6;

  localparam int          ST_HF           = 0;
  localparam int          ST_NDC          = 1;
  localparam int          ST_HMC          = 2;
  localparam int          ST_LRQ          = 3;
  localparam int          ST_RCB          = 4;
  localparam int          ST_LCB          = 5;
  localparam int          ST_CCA          = 6;
  localparam int          ST_ED           = 7;

  localparam logic [7:0]  REG_RESET_VAL   = 8'h00;
  localparam logic [4:0]  EXT_ECC_MAX     = 5'h1f;

  localparam int          RESET_BUS_CLKS  = 4;
  localparam logic [2:0]  RESET_CNT_LAST  = 3'(RESET_BUS_CLKS - 1);

  typedef enum logic [1:0] {
    CODE_NONE  = 2'h0,
    CODE_CRC16 = 2'h1,
    CODE_ECC32 = 2'h2,
    CODE_ECC48 = 2'h3
  } check_code_type;

  typedef struct packed {
    logic                header_done;
    logic                header_crc_err;
    logic                header_matched;
    logic                sector_found;
    logic                data_op_done;
    logic                remote_done;
    logic                local_busy;
    logic                local_dma_request;
    logic                correction_done;
    logic                compare_mode;
    logic                read_header_mode;
    logic                precomp_pins_mode;
    logic [REG_W-1:0]    error_bits;
  } disk_events_type;

  typedef struct packed {
    logic                mfm_encode;
    logic                mark_first_order;
    logic                sector_kind_select;
    logic                header_source_select;
    check_code_type      header_code;
    check_code_type      data_code;
    logic                external_code_needed;
    logic [4:0]          ext_ecc_max_bytes;
    logic                precomp_active;
    logic                remote_inbound_start;
    logic                remote_outbound_start;
    logic                correction_start;
    logic                read_header_abort;
    logic                standby;
  } disk_controls_type;

  typedef struct packed {
    logic [ADDR_W-1:0]   address;
    logic                read;
    logic                write;
    logic [DATA_W-1:0]   writedata;
    logic [3:0]          byteenable;
  } avalon_req_type;

  typedef struct packed {
    logic [DATA_W-1:0]   readdata;
    logic                waitrequest;
    logic                readdatavalid;
  } avalon_rsp_type;

endpackage : disk_ctrl_pkg

// [rtl/disk_ctrl_command_status_regs.sv]
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/100ps
// Functional notes
// - Header-done enable interrupts after each header
// - Bits start remote inbound or outbound DMA
// - Precompensation only when pins are precomp
// - Correction bit launches correction cycle
// - Interlock interrupts at header done while header match is high
// - Format bit zero selects NRZ versus MFM
// - Format bit one orders mark and preamble
// - Format bit two selects soft or hard
// - Header byte source chosen while formatting
// - Two-bit fields select header/data check codes
// - External code up to 31 bytes allowed
// - Reset pin or bit clears status flags, next-command flag set
// - Header fault sets, clears on find/command
// - Read header check error aborts, no errors
// - Next-command flag set ready, cleared on command
// - Header match flag set, cleared data end
// - Local request flag mirrors request pin
// - Remote busy from start to last transfer
// - Local busy while local channel moves data
// - Correction active from start to end
// - Error detected is OR of error bits
// - Global interrupt enable bit
// - Soft reset standby, held four bus clocks
module disk_ctrl_command_status_regs
  import disk_ctrl_pkg::*;
#(
  parameter int ADDR_WIDTH = ADDR_W
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst_n,
  input  wire disk_ctrl_pkg::avalon_req_type bus_req,
  output      disk_ctrl_pkg::avalon_rsp_type bus_rsp,
  input  wire disk_ctrl_pkg::disk_events_type events,
  output      disk_ctrl_pkg::disk_controls_type controls,
  output      logic                         irq
);

  typedef struct packed {
    logic [REG_W-1:0]  op_cmd;
    logic [REG_W-1:0]  format;
    logic [REG_W-1:0]  status;
    logic [2:0]        reset_cnt;
    avalon_rsp_type    rsp;
    disk_controls_type ctl;
    logic              irq;
  } state_type;

  state_type state_q;
  state_type state_d;

  logic [ADDR_W-3:0] idx;
  logic              wr_op;
  logic              wr_fmt;
  logic              wr_drive;
  logic              soft_rst;
  logic              hdr_irq;

  function automatic logic hit(input logic [ADDR_W-3:0] a, input logic [7:0] i);
    hit = ({2'h0, a} == i);
  endfunction : hit

  assign idx      = bus_req.address[ADDR_W-1:2];
  assign wr_op    = bus_req.write && !state_q.rsp.waitrequest && hit(idx, IDX_OP_CMD) && bus_req.byteenable[0];
  assign wr_fmt   = bus_req.write && !state_q.rsp.waitrequest && hit(idx, IDX_FORMAT) && bus_req.byteenable[0];
  assign wr_drive = bus_req.write && !state_q.rsp.waitrequest && hit(idx, IDX_DRIVE_CMD) && bus_req.byteenable[0];
  assign soft_rst = state_q.op_cmd[OC_RESET];
  // Count write is accepted and ignored: late-interlock tracking lives outside this block
  assign hdr_irq  = events.header_done && (state_q.op_cmd[OC_HDR_IE]
                    || (state_q.op_cmd[OC_LOCK] && events.header_matched));

  always_comb begin
    state_d = state_q;
    state_d.rsp.readdatavalid = 1'b0;
    // One wait cycle: request seen with waitrequest high, answered on the next edge
    state_d.rsp.waitrequest = !((bus_req.read || bus_req.write) && state_q.rsp.waitrequest);
    if (bus_req.read && state_q.rsp.waitrequest) begin
      state_d.rsp.readdata = '0;
      if (hit(idx, IDX_STATUS)) begin
        state_d.rsp.readdata[REG_W-1:0] = state_q.status;
      end else if (hit(idx, IDX_ERROR)) begin
        state_d.rsp.readdata[REG_W-1:0] = events.error_bits;
      end
      state_d.rsp.readdatavalid = 1'b1;
    end
    if (wr_op) begin
      state_d.op_cmd = bus_req.writedata[REG_W-1:0];
    end
    if (wr_fmt) begin
      state_d.format = bus_req.writedata[REG_W-1:0];
    end
    // Start bits act once per write, so they are pulses not levels
    state_d.ctl.remote_inbound_start  = wr_op && bus_req.writedata[OC_RIN];
    state_d.ctl.remote_outbound_start = wr_op && bus_req.writedata[OC_ROUT];
    state_d.ctl.correction_start      = wr_op && bus_req.writedata[OC_CORR];
    state_d.ctl.precomp_active = state_q.op_cmd[OC_PRECOMP] && events.precomp_pins_mode;
    state_d.ctl.mfm_encode           = state_q.format[DF_MFM];
    state_d.ctl.mark_first_order     = state_q.format[DF_MARK_FIRST];
    state_d.ctl.sector_kind_select   = state_q.format[DF_HARD];
    state_d.ctl.header_source_select = state_q.format[DF_HDR_SRC];
    state_d.ctl.header_code = check_code_type'(state_q.format[DF_HCODE_LO +: 2]);
    state_d.ctl.data_code   = check_code_type'(state_q.format[DF_DCODE_LO +: 2]);
    state_d.ctl.external_code_needed = (state_q.format[DF_HCODE_LO +: 2] == CODE_NONE);
    state_d.ctl.ext_ecc_max_bytes    = EXT_ECC_MAX;
    state_d.ctl.read_header_abort = events.read_header_mode && events.header_crc_err;
    // Status flags: set wins over clear
    if (events.sector_found || wr_drive) begin
      state_d.status[ST_HF] = 1'b0;
    end
    if (events.header_crc_err) begin
      state_d.status[ST_HF] = 1'b1;
    end
    if (wr_drive) begin
      state_d.status[ST_NDC] = 1'b0;
    end
    if (events.header_done) begin
      state_d.status[ST_NDC] = 1'b1;
    end
    if (events.data_op_done) begin
      state_d.status[ST_HMC] = 1'b0;
    end
    if (events.header_matched && (events.compare_mode || events.header_done)) begin
      state_d.status[ST_HMC] = 1'b1;
    end
    state_d.status[ST_LRQ] = events.local_dma_request;
    if (events.remote_done) begin
      state_d.status[ST_RCB] = 1'b0;
    end
    if (wr_op && (bus_req.writedata[OC_RIN] || bus_req.writedata[OC_ROUT])) begin
      state_d.status[ST_RCB] = 1'b1;
    end
    state_d.status[ST_LCB] = events.local_busy;
    if (events.correction_done) begin
      state_d.status[ST_CCA] = 1'b0;
    end
    if (wr_op && bus_req.writedata[OC_CORR]) begin
      state_d.status[ST_CCA] = 1'b1;
    end
    state_d.status[ST_ED] = |events.error_bits;
    state_d.irq = hdr_irq && state_q.op_cmd[OC_GIE];
    // Standby needs the bit held several bus clocks before it takes hold
    if (soft_rst && state_q.reset_cnt != RESET_CNT_LAST) begin
      state_d.reset_cnt = state_q.reset_cnt + 3'h1;
    end else if (!soft_rst) begin
      state_d.reset_cnt = '0;
    end
    state_d.ctl.standby = soft_rst && state_q.reset_cnt == RESET_CNT_LAST;
    if (soft_rst) begin
      state_d.status = REG_RESET_VAL;
      state_d.status[ST_NDC] = 1'b1;
      state_d.irq = 1'b0;
      state_d.ctl.remote_inbound_start  = 1'b0;
      state_d.ctl.remote_outbound_start = 1'b0;
      state_d.ctl.correction_start      = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= '0;
      state_q.rsp.waitrequest <= 1'b1;
      state_q.status[ST_NDC] <= 1'b1;
    end else begin
      state_q <= state_d;
    end
  end

  assign bus_rsp  = state_q.rsp;
  assign controls = state_q.ctl;
  assign irq      = state_q.irq;

  a_rsp_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (bus_req.read && state_q.rsp.waitrequest) |=> !state_q.rsp.waitrequest)
    else $error("read not answered in one cycle");
  a_status_reset: assert property (@(posedge ref_clk) disable iff (!rst_n)
    soft_rst |=> (state_q.status[ST_HF] == 1'b0 && state_q.status[ST_NDC]))
    else $error("soft reset left status set");
  a_hf_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (events.header_crc_err && !soft_rst) |=> state_q.status[ST_HF])
    else $error("header fault not set");
  a_ndc_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_drive && !events.header_done && !soft_rst) |=> !state_q.status[ST_NDC])
    else $error("next command flag not cleared");
  a_lrq_mirror: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !soft_rst |=> state_q.status[ST_LRQ] == $past(events.local_dma_request))
    else $error("local request flag differs from pin");
  a_err_or: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !soft_rst |=> state_q.status[ST_ED] == $past(|events.error_bits))
    else $error("error detected not OR of errors");
  a_irq_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irq |-> $past(state_q.op_cmd[OC_GIE]))
    else $error("interrupt without global enable");
  a_precomp_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
    controls.precomp_active |-> $past(events.precomp_pins_mode))
    else $error("precompensation with pins not in precomp mode");
  a_cca_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_op && bus_req.writedata[OC_CORR] && !soft_rst) |=> (state_q.status[ST_CCA] && controls.correction_start))
    else $error("correction start not flagged");
  a_rcb_start: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (wr_op && (bus_req.writedata[OC_RIN] || bus_req.writedata[OC_ROUT]) && !soft_rst) |=> state_q.status[ST_RCB])
    else $error("remote busy not set on start");
  a_hdr_irq: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (events.header_done && state_q.op_cmd[OC_HDR_IE] && state_q.op_cmd[OC_GIE] && !soft_rst) |=> irq)
    else $error("header done interrupt missing");
  a_wait_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(bus_req.read || bus_req.write) |=> state_q.rsp.waitrequest)
    else $error("waitrequest low without request");
  a_standby_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(controls.standby) |-> $past(soft_rst, 4))
    else $error("standby before four clocks of reset bit");

endmodule : disk_ctrl_command_status_regs

// [verification/host_model.sv]
`timescale 1ns/100ps
module host_model (
  input  wire logic                          ref_clk,
  output      disk_ctrl_pkg::avalon_req_type bus_req,
  input  wire disk_ctrl_pkg::avalon_rsp_type bus_rsp
);
  import disk_ctrl_pkg::*;

  initial bus_req = '0;

  // Request stays put until waitrequest is seen low; the bench timeout covers a dead slave
  task automatic access(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    bus_req <= '{address: a, read: !w, write: w, writedata: d, byteenable: 4'hf};
    do begin
      @(posedge ref_clk);
    end while (bus_rsp.waitrequest !== 1'b0);
    q = bus_rsp.readdata;
    bus_req.read  <= 1'b0;
    bus_req.write <= 1'b0;
  endtask : access

  // Count write tells the device the interlock update is finished
  task automatic interlock_done(input logic [7:0] count);
    logic [31:0] unused;
    access(8'h3c, 1'b1, {24'h0, count}, unused);
  endtask : interlock_done
endmodule : host_model

// [verification/tb.sv]
`timescale 1ns/100ps
module tb;
  import disk_ctrl_pkg::*;
  logic              ref_clk;
  logic              rst_n;
  logic              irq;
  avalon_req_type    bus_req;
  avalon_rsp_type    bus_rsp;
  disk_events_type   ev;
  disk_controls_type ctl;
  logic [31:0]       q;
  logic [7:0]        d;
  int                n_errors, check_count, cyc, n_irq, n_in, n_out, n_corr, n_abort;
  int                n_rv, n_rd;
  int                starts[3] = '{OC_RIN, OC_ROUT, OC_CORR};
  localparam disk_events_type ev_hdr   = '{header_done: 1'b1, default: '0};
  localparam disk_events_type ev_match = '{header_matched: 1'b1, default: '0};
  localparam disk_events_type ev_crc   = '{header_crc_err: 1'b1, default: '0};
  localparam disk_events_type ev_found = '{sector_found: 1'b1, default: '0};
  localparam disk_events_type ev_data  = '{data_op_done: 1'b1, default: '0};
  localparam disk_events_type ev_rdone = '{remote_done: 1'b1, default: '0};
  localparam disk_events_type ev_cdone = '{correction_done: 1'b1, default: '0};

  disk_ctrl_command_status_regs disk_ctrl_command_status_regs_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .bus_req(bus_req), .bus_rsp(bus_rsp), .events(ev), .controls(ctl), .irq(irq));
  host_model host_model_inst (.ref_clk(ref_clk), .bus_req(bus_req), .bus_rsp(bus_rsp));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    n_irq   += (irq === 1'b1);
    n_in    += (ctl.remote_inbound_start === 1'b1);
    n_out   += (ctl.remote_outbound_start === 1'b1);
    n_corr  += (ctl.correction_start === 1'b1);
    n_abort += (ctl.read_header_abort === 1'b1);
    n_rv    += (bus_rsp.readdatavalid === 1'b1);
    if (++cyc == 3000) begin
      n_errors++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic rd(input logic [7:0] a);
    n_rd++;
    host_model_inst.access(a, 1'b0, 32'h0, q);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    logic [31:0] unused;
    host_model_inst.access(a, 1'b1, {24'h0, v}, unused);
    repeat (2) @(posedge ref_clk);
  endtask : wr

  task automatic pulse(input disk_events_type m);
    @(posedge ref_clk);
    ev <= ev | m;
    @(posedge ref_clk);
    ev <= ev & ~m;
  endtask : pulse

  // Format byte to the control fields it should produce
  function automatic logic [31:0] exp_fmt(input logic [7:0] f);
    return 32'({f[0], f[1], f[2], f[3], f[5:4], f[7:6], f[5:4] == 2'b00, 5'd31});
  endfunction : exp_fmt

  initial begin
    rst_n = 1'b0;
    ev = '0;
    void'($urandom(32'h549d984b));
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(8'h00);
    check(q, 32'h2);
    rd(8'h08);
    check(q, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      d[5:4] = 2'(i);
      d[7:6] = 2'(3 - i);
      wr(8'hd4, d);
      check(32'({ctl.mfm_encode, ctl.mark_first_order, ctl.sector_kind_select, ctl.header_source_select,
        ctl.header_code, ctl.data_code, ctl.external_code_needed, ctl.ext_ecc_max_bytes}), exp_fmt(d));
    end
    $display("test format done");
    for (int i = 0; i < 6; i++) begin
      @(posedge ref_clk);
      ev.local_dma_request <= 1'($urandom);
      ev.local_busy <= 1'($urandom);
      ev.error_bits <= 8'($urandom) & {8{i[0]}};
      rd(8'h00);
      check({q[7], q[5], q[3]}, {|ev.error_bits, ev.local_busy, ev.local_dma_request});
    end
    ev <= '0;
    $display("test mirror done");
    foreach (starts[i]) begin
      wr(8'h44, 8'(1 << starts[i]));
      rd(8'h00);
      check(q & 32'h50, (starts[i] == OC_CORR) ? 32'h40 : 32'h10);
      pulse((starts[i] == OC_CORR) ? ev_cdone : ev_rdone);
      rd(8'h00);
      check(q & 32'h50, 32'h0);
    end
    check(n_in, 1);
    check(n_out, 1);
    check(n_corr, 1);
    wr(8'h44, 8'h20);
    check(ctl.precomp_active, 1'b0);
    ev.precomp_pins_mode <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check(ctl.precomp_active, 1'b1);
    $display("test start bits done");
    wr(8'h44, 8'h06);
    pulse(ev_hdr);
    wr(8'h44, 8'h04);
    pulse(ev_hdr);
    wr(8'h44, 8'h82);
    pulse(ev_hdr | ev_match);
    repeat (3) @(posedge ref_clk);
    check(n_irq, 2);
    rd(8'h00);
    check(q & 32'h7, 32'h6);
    host_model_inst.interlock_done(8'h04);
    pulse(ev_crc);
    rd(8'h00);
    check(q[0], 1'b1);
    pulse(ev_found);
    rd(8'h00);
    check(q[0], 1'b0);
    pulse(ev_crc);
    wr(8'h40, 8'h00);
    pulse(ev_data);
    rd(8'h00);
    check(q & 32'h7, 32'h0);
    ev.read_header_mode <= 1'b1;
    pulse(ev_crc);
    rd(8'h04);
    check(q, 32'h0);
    check(n_abort, 1);
    $display("test header done");
    pulse(ev_hdr | ev_match);
    wr(8'h44, 8'h01);
    repeat (4) @(posedge ref_clk);
    check(ctl.standby, 1'b1);
    rd(8'h00);
    check(q, 32'h2);
    wr(8'h44, 8'h00);
    // One valid pulse per read answer
    check(n_rv, n_rd);
    $display("test soft reset done");
    stop_test();
  end
endmodule : tb
